/* File: logic/ser_pkg.sv */
/*
 * Constants for the status and event reporting block: register offsets,
 * summary byte bit positions, field widths and reset values.
 * Assumes a 32-bit APB register bus with word-aligned registers.
 */
`default_nettype none

package ser_pkg;

    // Field widths
    localparam int OPQ_W  = 15;          // Operation and questionable width
    localparam int STD_W  = 7;           // Standard event and request enable width
    localparam int ERR_W  = 16;          // Encoded error number width
    localparam int ADDR_W = 8;           // Decoded APB address bits

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_SUMMARY   = 8'h00; // Summary byte, read only
    localparam logic [ADDR_W-1:0] OFF_SRV_EN    = 8'h04; // Service request enable
    localparam logic [ADDR_W-1:0] OFF_STD_EVT   = 8'h08; // Standard event, read clears
    localparam logic [ADDR_W-1:0] OFF_STD_EN    = 8'h0c; // Standard event enable
    localparam logic [ADDR_W-1:0] OFF_OPER_EVT  = 8'h10; // Operation event, read clears
    localparam logic [ADDR_W-1:0] OFF_OPER_COND = 8'h14; // Operation condition
    localparam logic [ADDR_W-1:0] OFF_OPER_EN   = 8'h18; // Operation enable
    localparam logic [ADDR_W-1:0] OFF_QUES_EVT  = 8'h1c; // Questionable event, read clears
    localparam logic [ADDR_W-1:0] OFF_QUES_COND = 8'h20; // Questionable condition
    localparam logic [ADDR_W-1:0] OFF_QUES_EN   = 8'h24; // Questionable enable
    localparam logic [ADDR_W-1:0] OFF_ERR_QUEUE = 8'h28; // Error queue, read clears
    localparam logic [ADDR_W-1:0] OFF_CONTROL   = 8'h2c; // Clear and preset strobes
    localparam logic [ADDR_W-1:0] OFF_IRQ_STS   = 8'h30; // Interrupt status, write one clears
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 8'h34; // Interrupt mask

    // Summary byte bit positions
    localparam int SUM_ERR  = 2;         // Error queue not empty
    localparam int SUM_QUES = 3;         // Questionable summary
    localparam int SUM_STD  = 5;         // Standard event summary
    localparam int SUM_RQS  = 6;         // Service request summary bit
    localparam int SUM_OPER = 7;         // Operation summary

    // Control register bits
    localparam int CTL_CLEAR  = 0;       // Clear all event registers and queue
    localparam int CTL_PRESET = 1;       // Clear operation and questionable enables

    // Interrupt status bits
    localparam int IRQ_W      = 2;       // Interrupt status width
    localparam int IRQ_ERR    = 0;       // Error code recorded
    localparam int IRQ_SRQ    = 1;       // Service request became active

    // Reset values
    localparam logic [OPQ_W-1:0] OPQ_EN_RST = 15'h0000; // Preset state of enables
    localparam logic [STD_W-1:0] STD_EN_RST = 7'h00;    // Power-on standard enables

endpackage : ser_pkg

`default_nettype wire

/* File: logic/ser_top.sv */
/*
 * Status and event reporting block: condition views, rising-edge latched
 * event registers, a one-entry error queue, the summary byte with its
 * service request bit, the open-drain service request pin and an APB slave.
 * Assumes condition and event inputs synchronous to I_CLK and an APB master
 * that holds its request until it sees PREADY high.
 */
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

module ser_top
(
    input  wire logic                        I_CLK,       // 10 MHz clock
    input  wire logic                        I_RST,       // Async reset, high
    input  wire logic                        PSEL,        // APB select
    input  wire logic                        PENABLE,     // APB access phase
    input  wire logic                        PWRITE,      // APB write
    input  wire logic [ser_pkg::ADDR_W-1:0]  PADDR,       // APB byte address
    input  wire logic [31:0]                 PWDATA,      // APB write data
    output logic      [31:0]                 PRDATA,      // APB read data
    output logic                             PREADY,      // APB ready
    output logic                             PSLVERR,     // APB unmapped address
    input  wire logic [ser_pkg::OPQ_W-1:0]   I_OPER_COND, // Operation conditions
    input  wire logic [ser_pkg::OPQ_W-1:0]   I_QUES_COND, // Questionable conditions
    input  wire logic [ser_pkg::STD_W-1:0]   I_STD_SRC,   // Standard event sources
    input  wire logic                        I_ERR_VALID, // Error code strobe
    input  wire logic [ser_pkg::ERR_W-1:0]   I_ERR_CODE,  // Encoded error number
    input  wire logic                        I_SRQ_I,     // Request line level
    output logic                             O_SRQ_O,     // Request line drive value
    output logic                             O_SRQ_OE_N,  // Request drive enable, low
    output logic                             O_IRQ        // Level interrupt
);
    import ser_pkg::*;

    typedef struct packed {
        logic [OPQ_W-1:0] oper_cond;   // Condition view, operation
        logic [OPQ_W-1:0] ques_cond;   // Condition view, questionable
        logic [STD_W-1:0] std_prev;    // Previous standard sources
        logic [OPQ_W-1:0] oper_evt;    // Latched operation events
        logic [OPQ_W-1:0] ques_evt;    // Latched questionable events
        logic [STD_W-1:0] std_evt;     // Latched standard events
        logic [OPQ_W-1:0] oper_en;     // Operation enable
        logic [OPQ_W-1:0] ques_en;     // Questionable enable
        logic [STD_W-1:0] std_en;      // Standard enable
        logic [STD_W-1:0] srv_en;      // Service request enable
        logic [ERR_W-1:0] err_code;    // Queue contents
        logic             err_full;    // Queue holds a code
        logic [7:0]       summary;     // Summary byte
        logic [IRQ_W-1:0] irq_sts;     // Sticky interrupt status
        logic [IRQ_W-1:0] irq_mask;    // Interrupt mask
        logic             irq;         // Interrupt output
        logic             srq_oe_n;    // Request pin enable
        logic [31:0]      rdata;       // Read data
        logic             ready;       // Access phase ready
        logic             slverr;      // Unmapped access
    } ser_state_t;

    ser_state_t st_q;
    ser_state_t st_d;

    logic [OPQ_W-1:0] oper_rise;
    logic [OPQ_W-1:0] ques_rise;
    logic [STD_W-1:0] std_rise;
    logic             setup;
    logic             access;
    logic             wr;
    logic             rd;
    logic             mapped;
    logic             clr_all;
    logic             rqs_next;
    logic [7:0]       sum_next;
    logic [31:0]      rd_mux;

    ////////////////////////////////////////////////////////////////////////////

    // Rising edges against the previous sample; falling edges are ignored
    assign oper_rise = I_OPER_COND & ~st_q.oper_cond;
    assign ques_rise = I_QUES_COND & ~st_q.ques_cond;
    assign std_rise  = I_STD_SRC & ~st_q.std_prev;

    // Bus phases; side effects happen only at the completing access edge
    assign setup  = PSEL & ~PENABLE;
    assign access = PSEL & PENABLE & st_q.ready;
    assign wr     = access & PWRITE & ~st_q.slverr;
    assign rd     = access & ~PWRITE & ~st_q.slverr;

    // Address decode, also used for the error answer
    always_comb begin
        mapped = 1'b1;
        unique case (PADDR)
            OFF_SUMMARY, OFF_SRV_EN, OFF_STD_EVT, OFF_STD_EN,
            OFF_OPER_EVT, OFF_OPER_COND, OFF_OPER_EN,
            OFF_QUES_EVT, OFF_QUES_COND, OFF_QUES_EN,
            OFF_ERR_QUEUE, OFF_CONTROL, OFF_IRQ_STS, OFF_IRQ_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Read view; condition and event are separate registers, the address picks one
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (PADDR)
            OFF_SUMMARY:   rd_mux[7:0]       = st_q.summary;
            OFF_SRV_EN:    rd_mux[STD_W-1:0] = st_q.srv_en;
            OFF_STD_EVT:   rd_mux[STD_W-1:0] = st_q.std_evt;
            OFF_STD_EN:    rd_mux[STD_W-1:0] = st_q.std_en;
            OFF_OPER_EVT:  rd_mux[OPQ_W-1:0] = st_q.oper_evt;
            OFF_OPER_COND: rd_mux[OPQ_W-1:0] = st_q.oper_cond;
            OFF_OPER_EN:   rd_mux[OPQ_W-1:0] = st_q.oper_en;
            OFF_QUES_EVT:  rd_mux[OPQ_W-1:0] = st_q.ques_evt;
            OFF_QUES_COND: rd_mux[OPQ_W-1:0] = st_q.ques_cond;
            OFF_QUES_EN:   rd_mux[OPQ_W-1:0] = st_q.ques_en;
            OFF_ERR_QUEUE: rd_mux[ERR_W:0]   = {st_q.err_full, st_q.err_code};
            OFF_CONTROL:   rd_mux[2]         = I_SRQ_I;
            OFF_IRQ_STS:   rd_mux[IRQ_W-1:0] = st_q.irq_sts;
            OFF_IRQ_MASK:  rd_mux[IRQ_W-1:0] = st_q.irq_mask;
            default:       rd_mux            = 32'h0000_0000;
        endcase
    end

    assign clr_all = wr && (PADDR == OFF_CONTROL) && PWDATA[CTL_CLEAR];

    ////////////////////////////////////////////////////////////////////////////

    // Next state of the whole block
    always_comb begin
        st_d = st_q;

        // Condition views follow the inputs; a read never touches them
        st_d.oper_cond = I_OPER_COND;
        st_d.ques_cond = I_QUES_COND;
        st_d.std_prev  = I_STD_SRC;

        // Event latches: clear by read or clear-status, a new edge wins
        if (clr_all || (rd && PADDR == OFF_OPER_EVT)) begin
            st_d.oper_evt = '0;
        end
        if (clr_all || (rd && PADDR == OFF_QUES_EVT)) begin
            st_d.ques_evt = '0;
        end
        if (clr_all || (rd && PADDR == OFF_STD_EVT)) begin
            st_d.std_evt = '0;
        end
        st_d.oper_evt = st_d.oper_evt | oper_rise;
        st_d.ques_evt = st_d.ques_evt | ques_rise;
        st_d.std_evt  = st_d.std_evt | std_rise;

        // Error queue: one entry, newest code replaces, read empties it
        if (clr_all || (rd && PADDR == OFF_ERR_QUEUE)) begin
            st_d.err_full = 1'b0;
            st_d.err_code = '0;
        end
        if (I_ERR_VALID) begin
            st_d.err_code = I_ERR_CODE;
            st_d.err_full = 1'b1;
        end

        // Enable writes, sized to their documented widths
        if (wr && PADDR == OFF_SRV_EN) begin
            st_d.srv_en = PWDATA[STD_W-1:0];
        end
        if (wr && PADDR == OFF_STD_EN) begin
            st_d.std_en = PWDATA[STD_W-1:0];
        end
        if (wr && PADDR == OFF_OPER_EN) begin
            st_d.oper_en = PWDATA[OPQ_W-1:0];
        end
        if (wr && PADDR == OFF_QUES_EN) begin
            st_d.ques_en = PWDATA[OPQ_W-1:0];
        end
        if (wr && PADDR == OFF_CONTROL && PWDATA[CTL_PRESET]) begin
            st_d.oper_en = OPQ_EN_RST;
            st_d.ques_en = OPQ_EN_RST;
        end

        // Summary byte from the event views and the queue flag only, then the request bit
        sum_next           = 8'h00;
        sum_next[SUM_ERR]  = st_q.err_full;
        sum_next[SUM_QUES] = |(st_q.ques_evt & st_q.ques_en);
        sum_next[SUM_STD]  = |(st_q.std_evt & st_q.std_en);
        sum_next[SUM_OPER] = |(st_q.oper_evt & st_q.oper_en);
        rqs_next = |({sum_next[SUM_OPER], sum_next[SUM_STD:0]}
                     & {1'b0, st_q.srv_en[SUM_STD:0]});
        sum_next[SUM_RQS]  = rqs_next;
        st_d.summary       = sum_next;

        // Open-drain pin pulls low while the request bit is set
        st_d.srq_oe_n = ~st_q.summary[SUM_RQS];

        // Interrupt status: write one clears, a same-cycle set wins
        if (wr && PADDR == OFF_IRQ_STS) begin
            st_d.irq_sts = st_q.irq_sts & ~PWDATA[IRQ_W-1:0];
        end
        if (wr && PADDR == OFF_IRQ_MASK) begin
            st_d.irq_mask = PWDATA[IRQ_W-1:0];
        end
        st_d.irq_sts[IRQ_ERR] = st_d.irq_sts[IRQ_ERR] | I_ERR_VALID;
        st_d.irq_sts[IRQ_SRQ] = st_d.irq_sts[IRQ_SRQ]
                              | (rqs_next & ~st_q.summary[SUM_RQS]);
        st_d.irq = |(st_q.irq_sts & st_q.irq_mask);

        // One wait-free access phase; data and error prepared in setup
        // Error flag stands only in the access cycle, so the pin needs no gate
        st_d.ready  = setup;
        st_d.slverr = setup & ~mapped;
        if (setup) begin
            st_d.rdata = PWRITE ? 32'h0000_0000 : rd_mux;
        end
    end

    // State register; constants only under reset
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            st_q          <= '0;
            st_q.oper_en  <= OPQ_EN_RST;
            st_q.ques_en  <= OPQ_EN_RST;
            st_q.std_en   <= STD_EN_RST;
            st_q.srv_en   <= STD_EN_RST;
            st_q.srq_oe_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Outputs straight from the state register, except O_SRQ_O which is tied low
    assign PRDATA     = st_q.rdata;
    assign PREADY     = st_q.ready;
    assign PSLVERR    = st_q.slverr;
    assign O_SRQ_O    = 1'b0;                 // Open drain only ever pulls low
    assign O_SRQ_OE_N = st_q.srq_oe_n;
    assign O_IRQ      = st_q.irq;

    ////////////////////////////////////////////////////////////////////////////

    // Checks beside the logic they guard
    a_rise_latches: assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_OPER_COND[0] && !st_q.oper_cond[0]) |=> st_q.oper_evt[0])
        else $error("operation rising edge not latched");

    a_fall_no_set: assert property (@(posedge I_CLK) disable iff (I_RST)
        (!st_q.oper_evt[1] && !(I_OPER_COND[1] && !st_q.oper_cond[1]))
        |=> !st_q.oper_evt[1])
        else $error("event bit set without rising edge");

    a_event_holds: assert property (@(posedge I_CLK) disable iff (I_RST)
        (st_q.ques_evt[0] && !clr_all && !(rd && PADDR == OFF_QUES_EVT))
        |=> st_q.ques_evt[0])
        else $error("event bit lost without clear");

    a_read_clears: assert property (@(posedge I_CLK) disable iff (I_RST)
        (rd && PADDR == OFF_STD_EVT && std_rise == '0) |=> st_q.std_evt == '0)
        else $error("standard event not cleared by read");

    a_cond_follows: assert property (@(posedge I_CLK) disable iff (I_RST)
        ##1 st_q.oper_cond == $past(I_OPER_COND))
        else $error("condition view lags its input");

    a_queue_summary: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_ERR_VALID |=> ##1 st_q.summary[SUM_ERR])
        else $error("queue summary not set after error");

    a_queue_empties: assert property (@(posedge I_CLK) disable iff (I_RST)
        (rd && PADDR == OFF_ERR_QUEUE && !I_ERR_VALID) |=> !st_q.err_full)
        else $error("queue not emptied by read");

    a_edge_wins: assert property (@(posedge I_CLK) disable iff (I_RST)
        (rd && PADDR == OFF_OPER_EVT && oper_rise[2]) |=> st_q.oper_evt[2])
        else $error("edge lost during read clear");

    a_rqs_cause: assert property (@(posedge I_CLK) disable iff (I_RST)
        st_q.summary[SUM_RQS] |-> $past(st_q.srv_en[SUM_STD:0]) != '0)
        else $error("request bit set with no enable");

    a_srq_follows: assert property (@(posedge I_CLK) disable iff (I_RST)
        st_q.summary[SUM_RQS] |=> !O_SRQ_OE_N)
        else $error("request pin not driven");

    a_sum_and: assert property (@(posedge I_CLK) disable iff (I_RST)
        ((st_q.oper_evt & st_q.oper_en) != '0) |=> st_q.summary[SUM_OPER])
        else $error("operation summary missing");

    a_cond_no_sum: assert property (@(posedge I_CLK) disable iff (I_RST)
        ((st_q.ques_evt & st_q.ques_en) == '0) |=> !st_q.summary[SUM_QUES])
        else $error("questionable summary without event");

    // Further checks on release of the pin, the queue, the standard latch, the condition view and the summary
    a_srq_release: assert property (@(posedge I_CLK) disable iff (I_RST)
        !st_q.summary[SUM_RQS] |=> O_SRQ_OE_N)
        else $error("request pin held with request bit clear");

    a_queue_code: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_ERR_VALID |=> (st_q.err_full && st_q.err_code == $past(I_ERR_CODE)))
        else $error("error code not recorded");

    a_std_latch: assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_STD_SRC[0] && !st_q.std_prev[0]) |=> st_q.std_evt[0])
        else $error("standard rising edge not latched");

    a_ques_sum: assert property (@(posedge I_CLK) disable iff (I_RST)
        ((st_q.ques_evt & st_q.ques_en) != '0) |=> st_q.summary[SUM_QUES])
        else $error("questionable summary missing");

    a_queue_clear: assert property (@(posedge I_CLK) disable iff (I_RST)
        !st_q.err_full |=> !st_q.summary[SUM_ERR])
        else $error("queue summary set while queue empty");

    a_rqs_set: assert property (@(posedge I_CLK) disable iff (I_RST)
        (st_q.summary[SUM_QUES] && $past(st_q.srv_en[SUM_QUES])) |-> st_q.summary[SUM_RQS])
        else $error("request bit missing for enabled summary");

    a_cond_read: assert property (@(posedge I_CLK) disable iff (I_RST)
        (rd && PADDR == OFF_QUES_COND) |=> st_q.ques_cond == $past(I_QUES_COND))
        else $error("condition view disturbed by a read");

    a_evt_only: assert property (@(posedge I_CLK) disable iff (I_RST)
        (st_q.oper_cond != '0 && st_q.oper_evt == '0) |=> !st_q.summary[SUM_OPER])
        else $error("operation condition fed the summary");

endmodule : ser_top

`default_nettype wire

/* File: verification/ser_ctrl_model.sv */
/*
 * Behavioural model of the remote controller end of the service request line.
 * Assumes the device pulls the line through an open-drain enable that is low
 * while it pulls; the line has a pull-up, so released means high.
 */
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

module ser_ctrl_model
(
    input  wire logic i_oe_n,    // Device pull enable, low active
    input  wire logic i_pull,    // Another bus party pulling the line
    output logic      o_line     // Wired line level
);
    // Wired AND of all pullers over the pull-up; the controller only listens
    assign o_line = (i_oe_n === 1'b0 || i_pull) ? 1'b0 : 1'b1;
endmodule : ser_ctrl_model

`default_nettype wire

/* File: verification/status_event_reporting_bench.sv */
/*
 * Self-checking bench for the status and event reporting block.
 * Assumes the package offsets and the one-wait-free APB answer of the design.
 */
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

module status_event_reporting_bench;
    import ser_pkg::*;
    logic              clk, rst, psel, pen, pwr, prdy, perr, evld, line, oe_n, srq_o, irq;
    logic [ADDR_W-1:0] padr;
    logic [31:0]       pwd, prd, r;
    logic [OPQ_W-1:0]  oc, qc;
    logic [STD_W-1:0]  sc;
    logic [ERR_W-1:0]  ecode;
    int                n_errors = 0;
    int                tests_run = 0;

    ser_top i_dut (.I_CLK(clk), .I_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
        .I_OPER_COND(oc), .I_QUES_COND(qc), .I_STD_SRC(sc), .I_ERR_VALID(evld),
        .I_ERR_CODE(ecode), .I_SRQ_I(line), .O_SRQ_O(srq_o), .O_SRQ_OE_N(oe_n), .O_IRQ(irq));
    ser_ctrl_model i_ctrl (.i_oe_n(oe_n), .i_pull(1'b0), .o_line(line));

    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Verdict, compares and bus cycles

    task conclude;
        if (n_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask : chk

    task chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask : chk1

    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // Request is held until pready is seen high; only the watchdog ends a wait
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwr  <= w;
        padr <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        r = prd;
        e = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic e;
        xfer(1'b1, a, d, e);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp);
        logic e;
        xfer(1'b0, a, 32'h0, e);
        chk(r, exp);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////
    // Hang guard, about a hundred times the expected run

    initial begin
        #2000000;
        $display("unexpected at %0t: run timed out", $time);
        n_errors++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test sequence

    initial begin
        logic e;
        rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; padr = '0; pwd = '0;
        oc = '0; qc = '0; sc = '0; evld = 1'b0; ecode = '0;
        tick(16);
        rst <= 1'b0;
        chk1(oe_n, 1'b1);
        rd(OFF_SUMMARY, 32'h0);
        rd(OFF_OPER_EN, 32'h0);
        // Unmapped place is refused with zero data
        xfer(1'b0, 8'h3c, 32'h0, e);
        chk1(e, 1'b1);
        chk(r, 32'h0);
        // Enable widths
        wr(OFF_OPER_EN, 32'hffffffff);
        rd(OFF_OPER_EN, 32'h00007fff);
        wr(OFF_SRV_EN, 32'hffffffff);
        rd(OFF_SRV_EN, 32'h0000007f);
        wr(OFF_STD_EN, 32'hffffffff);
        rd(OFF_STD_EN, 32'h0000007f);
        wr(OFF_SRV_EN, 32'h8);
        // Condition view against event view
        oc <= 15'h0020;
        tick(3);
        rd(OFF_OPER_COND, 32'h20);
        rd(OFF_OPER_COND, 32'h20);
        rd(OFF_OPER_EVT, 32'h20);
        rd(OFF_OPER_EVT, 32'h0);
        oc <= 15'h0;
        tick(3);
        rd(OFF_OPER_COND, 32'h0);
        rd(OFF_OPER_EVT, 32'h0);
        wr(OFF_OPER_COND, 32'hffff);
        rd(OFF_OPER_COND, 32'h0);
        oc <= 15'h0020;
        tick(1);
        oc <= 15'h0;
        tick(3);
        rd(OFF_OPER_EVT, 32'h20);
        // Summary from event and enable; condition alone does not feed it
        oc <= 15'h0001;
        tick(4);
        rd(OFF_SUMMARY, 32'h80);
        rd(OFF_OPER_EVT, 32'h1);
        tick(2);
        rd(OFF_SUMMARY, 32'h0);
        oc <= 15'h0;
        // Service request, pin and interrupt
        wr(OFF_IRQ_MASK, 32'h2);
        wr(OFF_QUES_EN, 32'h1);
        qc <= 15'h0001;
        tick(5);
        chk1(oe_n, 1'b0);
        chk1(srq_o, 1'b0);
        rd(OFF_SUMMARY, 32'h48);
        rd(OFF_CONTROL, 32'h0);
        chk1(irq, 1'b1);
        rd(OFF_IRQ_STS, 32'h2);
        wr(OFF_IRQ_STS, 32'h2);
        tick(2);
        chk1(irq, 1'b0);
        rd(OFF_QUES_EVT, 32'h1);
        tick(3);
        chk1(oe_n, 1'b1);
        rd(OFF_CONTROL, 32'h4);
        qc <= 15'h0;
        // Error queue keeps the newest code only; masked event stays silent
        @(posedge clk);
        evld  <= 1'b1;
        ecode <= 16'h1234;
        @(posedge clk);
        ecode <= 16'h0abc;
        @(posedge clk);
        evld <= 1'b0;
        tick(3);
        chk1(irq, 1'b0);
        rd(OFF_SUMMARY, 32'h4);
        rd(OFF_ERR_QUEUE, 32'h00010abc);
        tick(2);
        rd(OFF_ERR_QUEUE, 32'h0);
        rd(OFF_SUMMARY, 32'h0);
        rd(OFF_IRQ_STS, 32'h1);
        wr(OFF_IRQ_MASK, 32'h1);
        tick(2);
        chk1(irq, 1'b1);
        wr(OFF_IRQ_STS, 32'h1);
        tick(2);
        chk1(irq, 1'b0);
        // Standard events and clear-all
        sc <= 7'h05;
        tick(1);
        sc <= 7'h0;
        tick(3);
        rd(OFF_SUMMARY, 32'h20);
        wr(OFF_CONTROL, 32'h1);
        tick(2);
        rd(OFF_STD_EVT, 32'h0);
        rd(OFF_SUMMARY, 32'h0);
        // Preset clears only operation and questionable enables
        wr(OFF_CONTROL, 32'h2);
        rd(OFF_OPER_EN, 32'h0);
        rd(OFF_QUES_EN, 32'h0);
        rd(OFF_STD_EN, 32'h7f);
        conclude();
    end
endmodule : status_event_reporting_bench

`default_nettype wire
